// File: hdl/sisc_top.sv
/*
  interrupt status and clear logic of a serial peripheral controller,
  with a classic wishbone slave port and one level interrupt output.
  assumes event inputs are synchronous to CLK_SYS and level-true.
*/
`timescale 1ns/100ps
module sisc_top (
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic        WB_WE_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        CONTENTION_RAW,
  input  wire logic        RX_FULL_RAW,
  input  wire logic        RX_OVERFLOW_RAW,
  input  wire logic        RX_UNDERFLOW_RAW,
  input  wire logic        TX_OVERFLOW_RAW,
  input  wire logic        TX_EMPTY_RAW,
  output logic             IRQ
);
  localparam int N = sisc_pkg::SISC_NUM_EVENTS;

  // ==========================================================
  // raw event gathering
  logic [N-1:0] raw_event_flags;
  logic [N-1:0] raw_reg;

  assign raw_event_flags[sisc_pkg::SISC_BIT_CONTENTION] = CONTENTION_RAW;
  assign raw_event_flags[sisc_pkg::SISC_BIT_RX_FULL]    = RX_FULL_RAW;
  assign raw_event_flags[sisc_pkg::SISC_BIT_RX_OVF]     = RX_OVERFLOW_RAW;
  assign raw_event_flags[sisc_pkg::SISC_BIT_RX_UNF]     = RX_UNDERFLOW_RAW;
  assign raw_event_flags[sisc_pkg::SISC_BIT_TX_OVF]     = TX_OVERFLOW_RAW;
  assign raw_event_flags[sisc_pkg::SISC_BIT_TX_EMPTY]   = TX_EMPTY_RAW;

  // ==========================================================
  // bus decode
  logic       bus_req;
  logic       bus_wr;
  logic       bus_rd;
  logic       lane0;
  logic       hit_disable;
  logic       hit_enable;
  logic       hit_unmask;
  logic       hit_raw;
  logic       hit_pend;
  logic       ack_reg;

  // one access per request; ack drops the cycle after it rose
  assign bus_req     = WB_CYC_I & WB_STB_I & ~ack_reg;
  assign bus_wr      = bus_req & WB_WE_I;
  assign bus_rd      = bus_req & ~WB_WE_I;
  assign lane0       = WB_SEL_I[0];  // all flags live in byte lane 0
  assign hit_disable = (WB_ADR_I == sisc_pkg::SISC_OFS_DISABLE);
  assign hit_enable  = (WB_ADR_I == sisc_pkg::SISC_OFS_ENABLE);
  assign hit_unmask  = (WB_ADR_I == sisc_pkg::SISC_OFS_UNMASK);
  assign hit_raw     = (WB_ADR_I == sisc_pkg::SISC_OFS_RAW);
  assign hit_pend    = (WB_ADR_I == sisc_pkg::SISC_OFS_PEND);

  // ==========================================================
  // unmask state, set by enable and cleared by disable writes
  logic [N-1:0] unmask_reg;
  logic [N-1:0] unmask_next;
  logic [N-1:0] wr_bits;
  logic [N-1:0] en_bits;
  logic [N-1:0] dis_bits;
  logic [N-1:0] clr_bits;

  assign wr_bits     = (bus_wr & lane0) ? WB_DAT_I[N-1:0] : '0;
  assign en_bits     = hit_enable  ? wr_bits : '0;
  assign dis_bits    = hit_disable ? wr_bits : '0;
  assign clr_bits    = hit_pend    ? wr_bits : '0;  // zeros leave bits alone
  // enable wins if both hit the same bit in one cycle (cannot, distinct offsets)
  assign unmask_next = (unmask_reg & ~dis_bits) | en_bits;

  // ==========================================================
  // pending flags: only unmasked events latch
  logic [N-1:0] pend_set;
  logic [N-1:0] pending_event_flags_clear;

  assign pend_set = raw_reg & unmask_reg;

  sisc_flag_bank #(
    .N (N)
  ) u_flags (
    .clk     (CLK_SYS),
    .rst_n   (RESETN),
    .set_i   (pend_set),
    .clr_i   (clr_bits),
    .flags_o (pending_event_flags_clear)
  );

  // ==========================================================
  // read mux; reserved bits and unmapped offsets read zero
  logic [N-1:0]  rd_sel;
  logic [31:0]   rd_word;

  assign rd_sel  = hit_raw    ? raw_reg :
                   hit_pend   ? pending_event_flags_clear :
                   hit_unmask ? unmask_reg : '0;
  assign rd_word = {{(sisc_pkg::SISC_DATA_W - N){1'b0}}, rd_sel};

  // ==========================================================
  // state registers; raw flags sampled so the bus sees a stable word
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      raw_reg    <= sisc_pkg::SISC_FLAGS_RST;
      unmask_reg <= sisc_pkg::SISC_FLAGS_RST;
    end else begin
      raw_reg    <= raw_event_flags;
      unmask_reg <= unmask_next;
    end
  end

  // bus answer: ack one cycle after request, every offset answered
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ack_reg  <= 1'b0;
      WB_DAT_O <= sisc_pkg::SISC_WORD_ZERO;
    end else begin
      ack_reg  <= bus_req;
      WB_DAT_O <= bus_rd ? rd_word : sisc_pkg::SISC_WORD_ZERO;
    end
  end

  assign WB_ACK_O = ack_reg;

  // interrupt level registered from the next value of the pending flags
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(((pending_event_flags_clear & ~clr_bits) | pend_set));
    end
  end
endmodule

// File: pkg/sisc_pkg.sv
/*
  constants for the serial-port interrupt status and clear block:
  register offsets, event bit positions and reset values.
  assumes a 32-bit classic wishbone slave with word-aligned registers.
*/
package sisc_pkg;
  // ==========================================================
  // sizes
  localparam int          SISC_NUM_EVENTS = 6;
  localparam int          SISC_DATA_W     = 32;
  localparam int          SISC_ADDR_W     = 8;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0]  SISC_OFS_DISABLE = 8'h30;  // write-only source disable
  localparam logic [7:0]  SISC_OFS_UNMASK  = 8'h34;  // read-only unmask state
  localparam logic [7:0]  SISC_OFS_RAW     = 8'h38;  // read-only raw flags
  localparam logic [7:0]  SISC_OFS_PEND    = 8'h3C;  // pending flags, write-one clear
  localparam logic [7:0]  SISC_OFS_ENABLE  = 8'h2C;  // write-only source enable

  // ==========================================================
  // event bit positions
  localparam int          SISC_BIT_TX_EMPTY   = 0;
  localparam int          SISC_BIT_TX_OVF     = 1;
  localparam int          SISC_BIT_RX_UNF     = 2;
  localparam int          SISC_BIT_RX_OVF     = 3;
  localparam int          SISC_BIT_RX_FULL    = 4;
  localparam int          SISC_BIT_CONTENTION = 5;

  // ==========================================================
  // reset values
  localparam logic [5:0]  SISC_FLAGS_RST = 6'h00;
  localparam logic [31:0] SISC_WORD_ZERO = 32'h0000_0000;
endpackage

// File: hdl/sisc_flag_bank.sv
/*
  sticky pending flag bank: set by masked events, cleared by write-one.
  assumes set and clear strobes synchronous to clk; set wins over clear.
*/
`timescale 1ns/100ps
module sisc_flag_bank #(
  parameter int N = 6
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] set_i,
  input  wire logic [N-1:0] clr_i,
  output logic      [N-1:0] flags_o
);
  // ==========================================================
  // flag storage
  logic [N-1:0] flags_reg;
  logic [N-1:0] flags_next;

  // set beats clear so no event is lost in the clearing cycle
  assign flags_next = (flags_reg & ~clr_i) | set_i;
  assign flags_o    = flags_reg;

  // flags hold until cleared
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end
endmodule

// File: testbench/sisc_top_properties.sv
/* checker for the interrupt status block: bus answer, raw and pending
   words, irq level. assumes the port names of sisc_top. */
`timescale 1ns/100ps
module sisc_props (
  input logic        CLK_SYS, RESETN, WB_WE_I, WB_CYC_I, WB_STB_I, WB_ACK_O, IRQ,
  input logic [7:0]  WB_ADR_I,
  input logic [31:0] WB_DAT_I, WB_DAT_O,
  input logic [3:0]  WB_SEL_I,
  input logic        CONTENTION_RAW, RX_FULL_RAW, RX_OVERFLOW_RAW,
  input logic        RX_UNDERFLOW_RAW, TX_OVERFLOW_RAW, TX_EMPTY_RAW
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  // ==========================================================
  // helpers: event vector, read answers, clearing writes
  wire [5:0] raw    = {CONTENTION_RAW, RX_FULL_RAW, RX_OVERFLOW_RAW,
                       RX_UNDERFLOW_RAW, TX_OVERFLOW_RAW, TX_EMPTY_RAW};
  wire       rd_ack = WB_ACK_O && !WB_WE_I;
  wire       clr_wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0]
                      && WB_ADR_I == 8'h3C && WB_DAT_I[5:0] != 6'h00;
  sequence s_req; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
  sequence s_ans; WB_ACK_O ##1 !WB_ACK_O; endsequence
  // ==========================================================
  // raw read lags the inputs, so compare against two cycles back
  chk_ack_once: assert property (s_req |=> s_ans) else $error("ack shape wrong");
  chk_idle_data: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data off ack");
  chk_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:6] == 26'h0)
    else $error("upper bits set");
  chk_raw_rx: assert property (rd_ack && WB_ADR_I == 8'h38 |->
    WB_DAT_O[4:2] == $past(raw[4:2], 2)) else $error("raw rx bits wrong");
  chk_raw_misc: assert property (rd_ack && WB_ADR_I == 8'h38 |->
    {WB_DAT_O[5], WB_DAT_O[1:0]} == $past({raw[5], raw[1:0]}, 2)) else $error("raw bits wrong");
  chk_irq_pend: assert property (rd_ack && WB_ADR_I == 8'h3C && WB_DAT_O[5:0] != 6'h00 |-> IRQ)
    else $error("irq low while pending");
  chk_irq_cause: assert property ($rose(IRQ) |->
    ($past(raw) | $past(raw, 2) | $past(raw, 3)) != 6'h00) else $error("irq without event");
  chk_clear_cause: assert property ($fell(IRQ) |->
    $past(clr_wr) || $past(clr_wr, 2)) else $error("irq fell without clear");
endmodule
bind sisc_top sisc_props chk_u (.*);

// File: testbench/tb.sv
/* self-checking bench for sisc_top: table of event rows, then sticky,
   clearing, masking and reset cases. assumes the classic bus slave. */
`timescale 1ns/100ps
module tb;
  logic        clk = 1'b0, rstn = 1'b0, we = 1'b0, cyc = 1'b0, stb = 1'b0, irq, ack;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, dout, q;
  logic [3:0]  sel = 4'h0;
  logic [5:0]  raw = 6'h00;
  int          error_cnt = 0, checks = 0;
  // rows: event levels, enable mask, expected pending
  logic [5:0]  rows [8][3] = '{'{6'h01, 6'h3F, 6'h01}, '{6'h02, 6'h3F, 6'h02},
    '{6'h04, 6'h3F, 6'h04}, '{6'h08, 6'h3F, 6'h08}, '{6'h10, 6'h3F, 6'h10},
    '{6'h20, 6'h3F, 6'h20}, '{6'h3F, 6'h15, 6'h15}, '{6'h2A, 6'h00, 6'h00}};
  always #25 clk = ~clk;
  sisc_top dut_u (.CLK_SYS(clk), .RESETN(rstn), .WB_ADR_I(adr), .WB_DAT_I(dat),
    .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(dout),
    .WB_ACK_O(ack), .CONTENTION_RAW(raw[5]), .RX_FULL_RAW(raw[4]), .IRQ(irq),
    .RX_OVERFLOW_RAW(raw[3]), .RX_UNDERFLOW_RAW(raw[2]), .TX_OVERFLOW_RAW(raw[1]),
    .TX_EMPTY_RAW(raw[0]));
  // ==========================================================
  // verdict and compares
  task automatic report_and_stop;
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // one bus cycle; the idle edge first keeps strobes low between cycles
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dout;
    {cyc, stb, we} <= 3'b000;
    if (n >= 20) chk("ack", 32'h1, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [5:0] e);
    wb(1'b0, a, 32'h0);
    chk($sformatf("reg_%h", a), {26'h0, e}, q);
  endtask
  // ==========================================================
  // watchdog, far above the expected run
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    report_and_stop;
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h38, 6'h00);
    rd(8'h3C, 6'h00);
    rd(8'h34, 6'h00);
    rd(8'h40, 6'h00);
    foreach (rows[i]) begin
      wb(1'b1, 8'h30, 32'h3F);
      wb(1'b1, 8'h3C, 32'h3F);
      wb(1'b1, 8'h2C, {26'h0, rows[i][1]});
      raw <= rows[i][0];
      repeat (3) @(posedge clk);
      rd(8'h38, rows[i][0]);
      rd(8'h34, rows[i][1]);
      rd(8'h3C, rows[i][2]);
      chk("irq", {31'h0, rows[i][2] != 6'h00}, {31'h0, irq});
      raw <= 6'h00;
    end
    // one-cycle pulse, zero write, late mask, partial clear
    wb(1'b1, 8'h2C, 32'h3F);
    raw <= 6'h21;
    @(posedge clk);
    raw <= 6'h00;
    repeat (3) @(posedge clk);
    rd(8'h3C, 6'h21);
    wb(1'b1, 8'h38, 32'h3F);
    rd(8'h38, 6'h00);
    wb(1'b1, 8'h3C, 32'h0);
    chk("irq", 32'h1, {31'h0, irq});
    wb(1'b1, 8'h30, 32'h3F);
    rd(8'h34, 6'h00);
    wb(1'b1, 8'h3C, 32'h01);
    rd(8'h3C, 6'h20);
    wb(1'b1, 8'h3C, 32'h20);
    rd(8'h3C, 6'h00);
    // reset in mid-run with every event active
    wb(1'b1, 8'h2C, 32'h3F);
    raw <= 6'h3F;
    repeat (3) @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h34, 6'h00);
    rd(8'h3C, 6'h00);
    rd(8'h38, 6'h3F);
    chk("irq", 32'h0, {31'h0, irq});
    // a level still high re-latches in the clearing cycle: set beats clear
    wb(1'b1, 8'h2C, 32'h3F);
    repeat (3) @(posedge clk);
    wb(1'b1, 8'h3C, 32'h3F);
    rd(8'h3C, 6'h3F);
    chk("irq", 32'h1, {31'h0, irq});
    raw <= 6'h00;
    report_and_stop;
  end
endmodule
